// ### brb_bank.sv
// brb_bank: second special register bank behind an APB slave
//
// How it works
// - pin and watchdog resets load other-reset values, except into keep-on-other registers
// - port latch survives pin and watchdog resets
// - change flag clears on reset, re-sets on mismatch
// - pin 3 direction bit always reads one
// - pc high buffer: five bits, reset zero
// - limit timer count resets to zero always
// - limit timer period resets to all ones
//
// The APB interface to the registers is this design's own decision.
module brb_bank (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [brb_pkg::BRB_ADDR_W-1:0] paddr,
    input wire logic [brb_pkg::BRB_DATA_W-1:0] pwdata,
    output logic [brb_pkg::BRB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic change_mismatch,
    output brb_pkg::brb_regs_t regs,
    output logic irq
);
    import brb_pkg::*;

    logic [1:0] pin_sync_q;
    logic [1:0] mismatch_sync_q;
    logic pin_reset;
    logic mismatch;
    logic other_rst;
    logic [BRB_IDX_W-1:0] idx;
    logic wr_fire;
    logic [7:0] wdat;
    logic [7:0] rd_d;
    logic pready_q;
    logic [BRB_DATA_W-1:0] prdata_q;
    logic pslverr_q;
    logic [7:0] core_flags_q;
    logic change_flag_q;
    logic [2:0] evt_status_q;
    logic [2:0] evt_enable_q;
    logic irq_q;
    logic [7:0] int_hi;
    logic [2:0] evt_set;

    // pin-side levels pass two flops before use
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_q <= 2'b11;
            mismatch_sync_q <= 2'b00;
        end else begin
            pin_sync_q <= {pin_sync_q[0], ext_reset_pin_n};
            mismatch_sync_q <= {mismatch_sync_q[0], change_mismatch};
        end
    end

    assign pin_reset = ~pin_sync_q[1];
    assign mismatch = mismatch_sync_q[1];
    assign other_rst = pin_reset | watchdog_timeout;

    // apb decode: index is word address, low two bits ignored
    assign idx = paddr[BRB_ADDR_W-1:2];
    // a write that lands during a pin or watchdog reset is dropped
    assign wr_fire = psel & penable & pready_q & pwrite & ~other_rst;
    assign wdat = pwdata[7:0];

    // no wait states: ready rises in the first access cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= psel & ~penable;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= '0;
        end else if (psel & ~penable) begin
            prdata_q <= {{(BRB_DATA_W-8){1'b0}}, rd_d};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // plain registers; x and u entries become zero at power-up and hold
    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b1),
        .WMASK(MASK_ALL)) u_timer0 (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_TIMER0_COUNT),
        .wr_data(wdat), .value_q(regs.timer0_count));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_ALL)) u_pc_low (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_PC_LOW),
        .wr_data(wdat), .value_q(regs.pc_low));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b1),
        .WMASK(MASK_ALL)) u_ind_ptr (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_INDIRECT_PTR),
        .wr_data(wdat), .value_q(regs.indirect_ptr));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b1),
        .WMASK(MASK_PORT6)) u_port_latch (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_PORT_LATCH),
        .wr_data(wdat), .value_q(regs.port_latch));

    brb_reg #(.POR_VAL(RST_PORT_DIR), .OTHER_VAL(RST_PORT_DIR), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_SIX)) u_port_dir (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_PORT_DIR),
        .wr_data(wdat), .value_q(regs.port_dir));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_SIX)) u_negedge (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_NEGEDGE_EN),
        .wr_data(wdat), .value_q(regs.negedge_en));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_PC_HIGH)) u_pc_high (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_PC_HIGH),
        .wr_data(wdat), .value_q(regs.pc_high));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_INT_HI)) u_int_hi (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_INT_CTRL),
        .wr_data(wdat), .value_q(int_hi));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_SIX)) u_pullup (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_PULLUP_EN),
        .wr_data(wdat), .value_q(regs.pullup_en));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_SLEW)) u_slew (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_SLEW_CTRL),
        .wr_data(wdat), .value_q(regs.slew_ctrl));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b1),
        .WMASK(MASK_RESET_CAUSE)) u_rcause (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_RESET_CAUSE),
        .wr_data(wdat), .value_q(regs.reset_cause));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_ALL)) u_t2_count (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_T2_COUNT),
        .wr_data(wdat), .value_q(regs.t2_count));

    brb_reg #(.POR_VAL(RST_ONES), .OTHER_VAL(RST_ONES), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_ALL)) u_t2_period (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_T2_PERIOD),
        .wr_data(wdat), .value_q(regs.t2_period));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_TCTRL)) u_t2_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_T2_CTRL),
        .wr_data(wdat), .value_q(regs.t2_ctrl));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_ALL)) u_lt_count (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_LT_COUNT),
        .wr_data(wdat), .value_q(regs.lt_count));

    brb_reg #(.POR_VAL(RST_ONES), .OTHER_VAL(RST_ONES), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_ALL)) u_lt_period (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_LT_PERIOD),
        .wr_data(wdat), .value_q(regs.lt_period));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_TCTRL)) u_lt_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_LT_CTRL),
        .wr_data(wdat), .value_q(regs.lt_ctrl));

    brb_reg #(.POR_VAL(RST_ZERO), .OTHER_VAL(RST_ZERO), .KEEP_ON_OTHER(1'b0),
        .WMASK(MASK_LT_RSEL)) u_lt_rsel (.clk_sys(clk_sys), .rst_n(rst_n),
        .other_rst(other_rst), .wr_en(wr_fire && idx == IDX_LT_RSEL),
        .wr_data(wdat), .value_q(regs.lt_rsel));

    // core flags: timeout and power-down bits are not writable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_flags_q <= RST_CORE_POR;
        end else if (other_rst) begin
            // bank select clears; arithmetic flags ride through unchanged
            core_flags_q <= core_flags_q & ~MASK_BANK_SEL;
            if (watchdog_timeout) begin
                core_flags_q[BIT_TIMEOUT] <= 1'b0;
            end else begin
                core_flags_q[BIT_TIMEOUT] <= core_flags_q[BIT_TIMEOUT];
            end
        end else if (wr_fire && idx == IDX_CORE_FLAGS) begin
            core_flags_q <= (wdat & MASK_CORE_RW) | (core_flags_q & ~MASK_CORE_RW);
        end
    end

    assign regs.core_flags = core_flags_q;

    // change flag: cleared by any reset, set wins over software clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            change_flag_q <= 1'b0;
        end else if (other_rst) begin
            change_flag_q <= 1'b0;
        end else if (mismatch) begin
            change_flag_q <= 1'b1;
        end else if (wr_fire && idx == IDX_INT_CTRL) begin
            change_flag_q <= wdat[BIT_CHANGE_FLAG];
        end
    end

    assign regs.int_ctrl = {int_hi[7:1], change_flag_q};

    // sticky event status, write-one clear, set wins
    assign evt_set[EVT_CHANGE] = mismatch & ~change_flag_q & ~other_rst;
    assign evt_set[EVT_WATCHDOG] = watchdog_timeout;
    assign evt_set[EVT_PIN_RESET] = pin_reset;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_status_q <= '0;
        end else if (wr_fire && idx == IDX_EVT_CLEAR) begin
            evt_status_q <= (evt_status_q & ~wdat[2:0]) | evt_set;
        end else begin
            evt_status_q <= evt_status_q | evt_set;
        end
    end

    // enable survives pin resets so a handler can see why it restarted
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_enable_q <= '0;
        end else if (wr_fire && idx == IDX_EVT_ENABLE) begin
            evt_enable_q <= wdat[2:0] & MASK_EVT;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((evt_status_q | evt_set) & evt_enable_q);
        end
    end

    assign irq = irq_q;

    // read mux; indirect location is not a physical register
    always_comb begin
        rd_d = 8'h00;
        case (idx)
            IDX_TIMER0_COUNT: rd_d = regs.timer0_count;
            IDX_PC_LOW: rd_d = regs.pc_low;
            IDX_CORE_FLAGS: rd_d = core_flags_q;
            IDX_INDIRECT_PTR: rd_d = regs.indirect_ptr;
            IDX_PORT_LATCH: rd_d = regs.port_latch;
            IDX_PORT_DIR: begin
                rd_d = regs.port_dir;
                rd_d[BIT_PIN3_DIR] = 1'b1;
            end
            IDX_NEGEDGE_EN: rd_d = regs.negedge_en;
            IDX_PC_HIGH: rd_d = regs.pc_high;
            IDX_INT_CTRL: rd_d = regs.int_ctrl;
            IDX_PULLUP_EN: rd_d = regs.pullup_en;
            IDX_SLEW_CTRL: rd_d = regs.slew_ctrl;
            IDX_RESET_CAUSE: rd_d = regs.reset_cause;
            IDX_T2_COUNT: rd_d = regs.t2_count;
            IDX_T2_PERIOD: rd_d = regs.t2_period;
            IDX_T2_CTRL: rd_d = regs.t2_ctrl;
            IDX_LT_COUNT: rd_d = regs.lt_count;
            IDX_LT_PERIOD: rd_d = regs.lt_period;
            IDX_LT_CTRL: rd_d = regs.lt_ctrl;
            IDX_LT_RSEL: rd_d = regs.lt_rsel;
            IDX_EVT_STATUS: rd_d = {5'h00, evt_status_q};
            IDX_EVT_ENABLE: rd_d = {5'h00, evt_enable_q};
            default: rd_d = 8'h00;
        endcase
    end

endmodule : brb_bank

// ### brb_bank_properties.sv
// brb_bank_properties: port-level checker for the second register bank
module brb_bank_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [brb_pkg::BRB_ADDR_W-1:0] paddr,
    input wire logic [brb_pkg::BRB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic watchdog_timeout,
    input wire brb_pkg::brb_regs_t regs
);
    import brb_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_setup_s(logic [9:0] idx);
        psel && !penable && !pwrite && paddr[11:2] == idx;
    endsequence
    sequence wd_s;
        watchdog_timeout;
    endsequence
    pready_answer_a: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    pready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    reply_clean_a: assert property (pready |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("bad reply bits");
    pin3_reads_one_a: assert property (rd_setup_s(IDX_PORT_DIR) |=> prdata[BIT_PIN3_DIR])
        else $error("pin 3 direction read as zero");
    unmapped_zero_a: assert property ((rd_setup_s(10'h106) or rd_setup_s(10'h3FF)) |=>
        prdata == 32'h0) else $error("unmapped read not zero");
    latch_kept_a: assert property (wd_s |=> $stable(regs.port_latch))
        else $error("port latch changed by watchdog");
    count_cleared_a: assert property (wd_s |=> regs.lt_count == 8'h00)
        else $error("limit count not cleared");
    period_ones_a: assert property (wd_s |=> regs.lt_period == 8'hFF)
        else $error("limit period not all ones");
    pc_high_zero_a: assert property (wd_s |=> regs.pc_high == 8'h00)
        else $error("pc high buffer not cleared");
    pc_high_width_a: assert property (regs.pc_high[7:5] == 3'h0)
        else $error("pc high buffer wider than five bits");
    flag_cleared_a: assert property (wd_s |=> !regs.int_ctrl[BIT_CHANGE_FLAG])
        else $error("change flag kept over reset");
endmodule : brb_bank_checker

bind brb_bank brb_bank_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_timeout(watchdog_timeout), .regs(regs));

// ### brb_cpu_model.sv
// brb_cpu_model: core-side data path acting as the bus master
module brb_cpu_model (
    input wire logic clk_sys,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [brb_pkg::BRB_ADDR_W-1:0] paddr,
    output logic [brb_pkg::BRB_DATA_W-1:0] pwdata,
    input wire logic [brb_pkg::BRB_DATA_W-1:0] prdata,
    input wire logic pready,
    output logic bus_hung
);
    timeunit 1ns;
    timeprecision 1ps;
    import brb_pkg::*;
    initial begin
        psel <= 1'h0;
        penable <= 1'h0;
        pwrite <= 1'h0;
        paddr <= '0;
        pwdata <= '0;
        bus_hung <= 1'h0;
    end
    // one word per register; request held until pready seen at an edge
    task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'h1;
        @(posedge clk_sys);
        while (!pready && n < 64) begin
            @(posedge clk_sys);
            n++;
        end
        rd = prdata[7:0];
        psel <= 1'h0;
        penable <= 1'h0;
        // released data toggles so a stale value is never mistaken for live
        pwdata <= ~pwdata;
        if (n >= 64) bus_hung <= 1'h1;
    endtask : xfer
endmodule : brb_cpu_model

// ### brb_pkg.sv
// brb_pkg: constants and types for the second special register bank
package brb_pkg;

    localparam int unsigned BRB_ADDR_W = 12;
    localparam int unsigned BRB_IDX_W = 10;
    localparam int unsigned BRB_DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_INDIRECT_DATA = 10'h100;
    localparam logic [9:0] IDX_TIMER0_COUNT = 10'h101;
    localparam logic [9:0] IDX_PC_LOW = 10'h102;
    localparam logic [9:0] IDX_CORE_FLAGS = 10'h103;
    localparam logic [9:0] IDX_INDIRECT_PTR = 10'h104;
    localparam logic [9:0] IDX_PORT_LATCH = 10'h105;
    localparam logic [9:0] IDX_NEGEDGE_EN = 10'h108;
    localparam logic [9:0] IDX_PC_HIGH = 10'h10A;
    localparam logic [9:0] IDX_INT_CTRL = 10'h10B;
    localparam logic [9:0] IDX_PULLUP_EN = 10'h10C;
    localparam logic [9:0] IDX_SLEW_CTRL = 10'h10D;
    localparam logic [9:0] IDX_RESET_CAUSE = 10'h10F;
    localparam logic [9:0] IDX_T2_COUNT = 10'h110;
    localparam logic [9:0] IDX_T2_PERIOD = 10'h111;
    localparam logic [9:0] IDX_T2_CTRL = 10'h112;
    localparam logic [9:0] IDX_LT_COUNT = 10'h113;
    localparam logic [9:0] IDX_LT_PERIOD = 10'h114;
    localparam logic [9:0] IDX_LT_CTRL = 10'h115;
    localparam logic [9:0] IDX_LT_RSEL = 10'h116;
    localparam logic [9:0] IDX_PORT_DIR = 10'h085;
    localparam logic [9:0] IDX_EVT_STATUS = 10'h120;
    localparam logic [9:0] IDX_EVT_CLEAR = 10'h121;
    localparam logic [9:0] IDX_EVT_ENABLE = 10'h122;

    // writable bit masks
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [7:0] MASK_PORT6 = 8'h37;
    localparam logic [7:0] MASK_SIX = 8'h3F;
    localparam logic [7:0] MASK_PC_HIGH = 8'h1F;
    localparam logic [7:0] MASK_INT_HI = 8'hFE;
    localparam logic [7:0] MASK_SLEW = 8'h05;
    localparam logic [7:0] MASK_RESET_CAUSE = 8'h03;
    localparam logic [7:0] MASK_TCTRL = 8'h7F;
    localparam logic [7:0] MASK_LT_RSEL = 8'h1F;
    localparam logic [7:0] MASK_CORE_RW = 8'hE7;
    localparam logic [7:0] MASK_BANK_SEL = 8'hE0;
    localparam logic [2:0] MASK_EVT = 3'h7;

    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ONES = 8'hFF;
    localparam logic [7:0] RST_PORT_DIR = 8'h3F;
    localparam logic [7:0] RST_CORE_POR = 8'h18;

    // field positions
    localparam int unsigned BIT_PIN3_DIR = 3;
    localparam int unsigned BIT_TIMEOUT = 4;
    localparam int unsigned BIT_POWERDOWN = 3;
    localparam int unsigned BIT_CHANGE_FLAG = 0;
    localparam int unsigned EVT_CHANGE = 0;
    localparam int unsigned EVT_WATCHDOG = 1;
    localparam int unsigned EVT_PIN_RESET = 2;

    typedef struct packed {
        logic [7:0] timer0_count;
        logic [7:0] pc_low;
        logic [7:0] core_flags;
        logic [7:0] indirect_ptr;
        logic [7:0] port_latch;
        logic [7:0] port_dir;
        logic [7:0] negedge_en;
        logic [7:0] pc_high;
        logic [7:0] int_ctrl;
        logic [7:0] pullup_en;
        logic [7:0] slew_ctrl;
        logic [7:0] reset_cause;
        logic [7:0] t2_count;
        logic [7:0] t2_period;
        logic [7:0] t2_ctrl;
        logic [7:0] lt_count;
        logic [7:0] lt_period;
        logic [7:0] lt_ctrl;
        logic [7:0] lt_rsel;
    } brb_regs_t;

endpackage : brb_pkg

// ### brb_reg.sv
// brb_reg: one 8-bit control register with two reset classes
module brb_reg #(
    parameter logic [7:0] POR_VAL = 8'h00,
    parameter logic [7:0] OTHER_VAL = 8'h00,
    parameter bit KEEP_ON_OTHER = 1'b0,
    parameter logic [7:0] WMASK = 8'hFF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic other_rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value_q
);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= POR_VAL;
        end else if (other_rst) begin
            // keep-on-other registers ride through pin and watchdog resets
            if (!KEEP_ON_OTHER) begin
                value_q <= OTHER_VAL & WMASK;
            end
        end else if (wr_en) begin
            value_q <= (wr_data & WMASK) | (value_q & ~WMASK);
        end
    end
endmodule : brb_reg

// ### testbench.sv
// testbench: directed scenarios for the second register bank
module testbench import brb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, ext_reset_pin_n, watchdog_timeout, change_mismatch;
    logic psel, penable, pwrite, pready, pslverr, irq, bus_hung;
    logic [BRB_ADDR_W-1:0] paddr;
    logic [BRB_DATA_W-1:0] pwdata, prdata;
    brb_regs_t regs;
    int n_errors = 0;
    int samples_checked = 0;

    brb_cpu_model cpu_u (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .bus_hung(bus_hung));
    brb_bank dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_pin_n(ext_reset_pin_n),
        .watchdog_timeout(watchdog_timeout), .change_mismatch(change_mismatch),
        .regs(regs), .irq(irq));

    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [9:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        cpu_u.xfer(1'h1, idx, d, unused);
    endtask : wr
    task rd_chk(input logic [9:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        cpu_u.xfer(1'h0, idx, 8'h00, d);
        chk({24'h0, d}, {24'h0, exp});
    endtask : rd_chk
    task pulse_wd;
        @(posedge clk_sys) watchdog_timeout <= 1'h1;
        @(posedge clk_sys) watchdog_timeout <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask : pulse_wd
    // pin is synchronised, so hold it low past the two sync flops
    task pulse_pin;
        @(posedge clk_sys) ext_reset_pin_n <= 1'h0;
        repeat (4) @(posedge clk_sys);
        ext_reset_pin_n <= 1'h1;
        repeat (5) @(posedge clk_sys);
    endtask : pulse_pin

    task sc_power_up;
        rd_chk(IDX_LT_COUNT, 8'h00);
        rd_chk(IDX_LT_PERIOD, 8'hFF);
        rd_chk(IDX_PC_HIGH, 8'h00);
        rd_chk(IDX_PORT_DIR, 8'h3F);
        wr(IDX_PC_HIGH, 8'hFF);
        rd_chk(IDX_PC_HIGH, 8'h1F);
        wr(IDX_PORT_DIR, 8'h00);
        rd_chk(IDX_PORT_DIR, 8'h08);
    endtask : sc_power_up
    task sc_other_reset(input bit use_pin);
        wr(IDX_PORT_LATCH, 8'h15);
        wr(IDX_LT_COUNT, 8'h5A);
        rd_chk(IDX_LT_COUNT, 8'h5A);
        wr(IDX_LT_PERIOD, 8'h3C);
        wr(IDX_PC_HIGH, 8'h0A);
        wr(IDX_T2_PERIOD, 8'h11);
        wr(IDX_NEGEDGE_EN, 8'h2A);
        wr(IDX_CORE_FLAGS, 8'hFF);
        if (use_pin) pulse_pin();
        else pulse_wd();
        rd_chk(IDX_PORT_LATCH, 8'h15);
        rd_chk(IDX_LT_COUNT, 8'h00);
        rd_chk(IDX_LT_PERIOD, 8'hFF);
        rd_chk(IDX_PC_HIGH, 8'h00);
        rd_chk(IDX_T2_PERIOD, 8'hFF);
        rd_chk(IDX_NEGEDGE_EN, 8'h00);
        // timeout flag drops only on watchdog; bank select always clears
        rd_chk(IDX_CORE_FLAGS, use_pin ? 8'h1F : 8'h0F);
    endtask : sc_other_reset
    // power-up reset in mid-run clears what pin and watchdog resets keep
    task sc_power_cycle;
        @(posedge clk_sys) rst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd_chk(IDX_PORT_LATCH, 8'h00);
        rd_chk(IDX_CORE_FLAGS, RST_CORE_POR);
    endtask : sc_power_cycle
    task sc_change_flag;
        @(posedge clk_sys) change_mismatch <= 1'h1;
        repeat (5) @(posedge clk_sys);
        #1 chk({31'h0, regs.int_ctrl[BIT_CHANGE_FLAG]}, 32'h1);
        @(posedge clk_sys) watchdog_timeout <= 1'h1;
        @(posedge clk_sys) watchdog_timeout <= 1'h0;
        #1 chk({31'h0, regs.int_ctrl[BIT_CHANGE_FLAG]}, 32'h0);
        repeat (3) @(posedge clk_sys);
        #1 chk({31'h0, regs.int_ctrl[BIT_CHANGE_FLAG]}, 32'h1);
        @(posedge clk_sys) change_mismatch <= 1'h0;
        repeat (5) @(posedge clk_sys);
        pulse_wd();
        #1 chk({31'h0, regs.int_ctrl[BIT_CHANGE_FLAG]}, 32'h0);
    endtask : sc_change_flag
    task sc_unmapped;
        wr(10'h106, 8'hA5);
        rd_chk(10'h106, 8'h00);
        wr(10'h3FF, 8'hFF);
        rd_chk(10'h3FF, 8'h00);
    endtask : sc_unmapped
    task sc_irq;
        // change and watchdog events since the mid-run power-up reset
        rd_chk(IDX_EVT_STATUS, 8'h03);
        wr(IDX_EVT_ENABLE, 8'h00);
        wr(IDX_EVT_CLEAR, 8'h07);
        rd_chk(IDX_EVT_STATUS, 8'h00);
        pulse_wd();
        rd_chk(IDX_EVT_STATUS, 8'h02);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_EVT_ENABLE, 8'h02);
        repeat (2) @(posedge clk_sys);
        #1 chk({31'h0, irq}, 32'h1);
        rd_chk(IDX_EVT_CLEAR, 8'h00);
        wr(IDX_EVT_CLEAR, 8'h02);
        repeat (2) @(posedge clk_sys);
        #1 chk({31'h0, irq}, 32'h0);
        pulse_pin();
        rd_chk(IDX_EVT_STATUS, 8'h04);
    endtask : sc_irq

    task tally_and_finish;
        if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    always @(posedge bus_hung) begin
        n_errors++;
        tally_and_finish();
    end

    initial begin
        rst_n <= 1'h0;
        ext_reset_pin_n <= 1'h1;
        watchdog_timeout <= 1'h0;
        change_mismatch <= 1'h0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'h1;
        sc_power_up();
        sc_other_reset(1'b1);
        sc_other_reset(1'b0);
        sc_power_cycle();
        sc_change_flag();
        sc_unmapped();
        sc_irq();
        tally_and_finish();
    end
endmodule : testbench
